// ---- rtl/aux_cfg_pkg.sv ----
// Package for the auxiliary configuration bank: register indices,
// reset values, writable-bit masks, field positions and carriers.
// Assumes a 32-bit Wishbone bus where register index n sits at byte 4*n.
package aux_cfg_pkg;

	localparam int REG_W = 16;
	localparam int IDX_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CHARGE_PUMP = 8'h48;
	localparam logic [IDX_W-1:0] IDX_RSVD_A = 8'h50;
	localparam logic [IDX_W-1:0] IDX_RSVD_B = 8'h51;
	localparam logic [IDX_W-1:0] IDX_TEMP_EN = 8'h60;
	localparam logic [IDX_W-1:0] IDX_TEMP_OUT = 8'h61;
	localparam logic [IDX_W-1:0] IDX_SER_PWR = 8'h70;
	localparam logic [IDX_W-1:0] IDX_BLACKCAL = 8'h80;
	localparam logic [IDX_W-1:0] IDX_GEN_CFG = 8'h81;

	// Reset values
	localparam logic [REG_W-1:0] RST_CHARGE_PUMP = 16'h1200;
	localparam logic [REG_W-1:0] RST_RSVD = 16'h0000;
	localparam logic [REG_W-1:0] RST_TEMP_EN = 16'h0000;
	localparam logic [REG_W-1:0] RST_SER_PWR = 16'h0000;
	localparam logic [REG_W-1:0] RST_BLACKCAL = 16'h4008;
	localparam logic [REG_W-1:0] RST_GEN_CFG = 16'hC001;

	// Writable bits; others hold their reset value
	localparam logic [REG_W-1:0] WM_CHARGE_PUMP = 16'h7703;
	localparam logic [REG_W-1:0] WM_TEMP_EN = 16'h0001;
	localparam logic [REG_W-1:0] WM_SER_PWR = 16'h0007;
	localparam logic [REG_W-1:0] WM_BLACKCAL = 16'h87FF;
	localparam logic [REG_W-1:0] WM_GEN_CFG = 16'hFFFF;

	// Field positions
	localparam int CP_PD_EN_BIT = 0;
	localparam int CP_FD_EN_BIT = 1;
	localparam int CP_PD_TRIM_LSB = 8;
	localparam int CP_FD_TRIM_LSB = 12;
	localparam int TRIM_W = 3;
	localparam int TEMP_EN_BIT = 0;
	localparam int TEMP_W = 8;
	localparam int SER_CLK_BIT = 0;
	localparam int SER_SYNC_BIT = 1;
	localparam int SER_DATA_BIT = 2;
	localparam int DATA_LANES = 4;
	localparam int BLK_LEVEL_LSB = 0;
	localparam int BLK_LEVEL_W = 8;
	localparam int BLK_SAMP_LSB = 8;
	localparam int BLK_SAMP_W = 3;
	localparam int CRC_SEED_BIT = 15;

	// Analog control carriers
	typedef struct packed {
		logic pd_trans_enable;
		logic fd_enable;
		logic [TRIM_W-1:0] pd_trans_trim;
		logic [TRIM_W-1:0] fd_trim;
	} charge_pump_ctrl_t;

	typedef struct packed {
		logic clock_power_up;
		logic sync_power_up;
		logic [DATA_LANES-1:0] data_power_up;
	} serializer_ctrl_t;

endpackage : aux_cfg_pkg

// ---- rtl/cfg_word_reg.sv ----
// One 16-bit software register with byte-lane writes and a mask of
// writable bits. Assumes write strobe is a single-cycle pulse.
`timescale 1ns/1ps
module cfg_word_reg #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [1:0] sel_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] q_o
);
	logic [15:0] lane_mask;
	logic [15:0] wmask;

	// Byte lanes combined with fixed writable bits
	assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign wmask = lane_mask & WRITE_MASK;

	// Locked bits keep their reset value forever
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q_o <= RESET_VAL;
		else if (wr_i)
			q_o <= (q_o & ~wmask) | (wdata_i & wmask);
	end
endmodule : cfg_word_reg

// ---- rtl/black_level_avg.sv ----
// Averages 2**n black pixels and holds the latest mean.
// Assumes black pixels arrive flagged by a valid strobe, one per clock.
`timescale 1ns/1ps
module black_level_avg #(
	parameter int PIX_W = 10,
	parameter int SAMP_W = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [SAMP_W-1:0] log2_samples_i,
	input wire logic black_valid_i,
	input wire logic [PIX_W-1:0] black_pixel_i,
	output logic [PIX_W-1:0] mean_o,
	output logic mean_valid_o
);
	import aux_cfg_pkg::*;

	localparam int MAX_LOG = (1 << SAMP_W) - 1;
	localparam int ACC_W = PIX_W + MAX_LOG + 1;

	logic [ACC_W-1:0] acc_q;
	logic [MAX_LOG:0] count_q;
	logic [MAX_LOG:0] target;
	logic [ACC_W-1:0] sum_d;
	logic last;

	assign target = (MAX_LOG + 1)'(1) << log2_samples_i;
	assign sum_d = acc_q + ACC_W'(black_pixel_i);
	assign last = black_valid_i && (count_q + (MAX_LOG + 1)'(1) == target);

	// Accumulator and sample counter; restart after each full set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			acc_q <= '0;
			count_q <= '0;
		end
		else if (last)
		begin
			acc_q <= '0;
			count_q <= '0;
		end
		else if (black_valid_i)
		begin
			acc_q <= sum_d;
			count_q <= count_q + (MAX_LOG + 1)'(1);
		end
	end

	// Division by a power of two is a shift, so no divider is needed
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mean_o <= '0;
			mean_valid_o <= 1'b0;
		end
		else if (last)
		begin
			mean_o <= PIX_W'(sum_d >> log2_samples_i); // RULE10
			mean_valid_o <= 1'b1;
		end
	end
endmodule : black_level_avg

// ---- rtl/sensor_aux_config_regs.sv ----
// Auxiliary configuration bank: charge pumps, temperature diode,
// serializer power, black calibration and CRC seed, behind Wishbone.
// Assumes classic single-cycle Wishbone masters and one clock domain.
`timescale 1ns/1ps

// Summary of operation
// RULE1 - Charge-pump bit 0 enables the photodiode transfer pump and resets to zero.
// RULE2 - Charge-pump bit 1 enables the floating-diffusion pump and resets to zero.
// RULE3 - Charge-pump bits 10:8 hold the transfer trim (reset 2) and bits 14:12 the diffusion trim (reset 1).
// RULE4 - Temperature enable bit 0 turns the diode on and the register resets to zero.
// RULE5 - The temperature readout is read-only, shows an 8-bit reading in its low bits and ignores writes.
// RULE6 - Serializer bit 0 powers the output clock driver up, resetting to powered down.
// RULE7 - Serializer bit 1 powers the sync channel up.
// RULE8 - Serializer bit 2 powers all four data channels up or down together.
// RULE9 - Black-calibration bits 7:0 set the output black level, resetting to 8.
// RULE10 - Black calibration averages two to the power of bits 10:8 black pixels, resetting to zero.
// RULE11 - Black-calibration bit 15 picks an all-zero or all-one CRC seed, resetting to zero.
// RULE12 - Registers are 16 bits at base plus offset and reserved fields read their reset values.
module sensor_aux_config_regs #(
	parameter int PIX_W = 10,
	parameter int CRC_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Analog controls
	output aux_cfg_pkg::charge_pump_ctrl_t charge_pump_o,
	output logic temp_diode_enable_o,
	input wire logic [aux_cfg_pkg::TEMP_W-1:0] temp_reading_i,
	output aux_cfg_pkg::serializer_ctrl_t serializer_o,
	output logic [15:0] general_config_o,
	// Data path
	input wire logic black_valid_i,
	input wire logic [PIX_W-1:0] black_pixel_i,
	input wire logic pixel_valid_i,
	input wire logic [PIX_W-1:0] pixel_i,
	output logic pixel_valid_o,
	output logic [PIX_W-1:0] pixel_o,
	output logic [CRC_W-1:0] crc_seed_o
);
	import aux_cfg_pkg::*;

	logic [IDX_W-1:0] idx;
	logic req;
	logic wr;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [REG_W-1:0] rdata_d;
	logic [REG_W-1:0] cp_q;
	logic [REG_W-1:0] temp_en_q;
	logic [REG_W-1:0] ser_q;
	logic [REG_W-1:0] blk_q;
	logic [REG_W-1:0] gen_q;
	logic [TEMP_W-1:0] temp_q;
	logic [PIX_W-1:0] black_mean;
	logic mean_valid;
	logic signed [PIX_W+1:0] corrected;
	logic [PIX_W-1:0] pixel_q;
	logic pixel_valid_q;
	logic [CRC_W-1:0] crc_seed_q;

	// Bus decode; word index from byte address
	assign idx = wb_adr_i[IDX_W+1:2];
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;

	// One wait state, ack drops the cycle after it was given
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// Writable registers; locked bits stay at their reset values
	cfg_word_reg #(
		.RESET_VAL(RST_CHARGE_PUMP),
		.WRITE_MASK(WM_CHARGE_PUMP)
	) u_charge_pump (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr && idx == IDX_CHARGE_PUMP),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[15:0]),
		.q_o(cp_q)
	); // RULE1 RULE2 RULE3

	cfg_word_reg #(
		.RESET_VAL(RST_TEMP_EN),
		.WRITE_MASK(WM_TEMP_EN)
	) u_temp_enable (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr && idx == IDX_TEMP_EN),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[15:0]),
		.q_o(temp_en_q)
	); // RULE4

	cfg_word_reg #(
		.RESET_VAL(RST_SER_PWR),
		.WRITE_MASK(WM_SER_PWR)
	) u_serializer_power (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr && idx == IDX_SER_PWR),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[15:0]),
		.q_o(ser_q)
	); // RULE6 RULE7 RULE8

	cfg_word_reg #(
		.RESET_VAL(RST_BLACKCAL),
		.WRITE_MASK(WM_BLACKCAL)
	) u_black_cal (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr && idx == IDX_BLACKCAL),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[15:0]),
		.q_o(blk_q)
	); // RULE9 RULE10 RULE11

	cfg_word_reg #(
		.RESET_VAL(RST_GEN_CFG),
		.WRITE_MASK(WM_GEN_CFG)
	) u_general_config (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr && idx == IDX_GEN_CFG),
		.sel_i(wb_sel_i[1:0]),
		.wdata_i(wb_dat_i[15:0]),
		.q_o(gen_q)
	);

	// Temperature reading captured each clock; bus writes never reach it
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			temp_q <= '0;
		else
			temp_q <= temp_reading_i; // RULE5
	end

	// Read mux; reserved words and unmapped indices read zero
	always_comb
	begin
		rdata_d = '0;
		unique case (idx)
			IDX_CHARGE_PUMP: rdata_d = cp_q;
			IDX_RSVD_A: rdata_d = RST_RSVD; // RULE12
			IDX_RSVD_B: rdata_d = RST_RSVD; // RULE12
			IDX_TEMP_EN: rdata_d = temp_en_q;
			IDX_TEMP_OUT: rdata_d = {{(REG_W - TEMP_W){1'b0}}, temp_q}; // RULE5
			IDX_SER_PWR: rdata_d = ser_q;
			IDX_BLACKCAL: rdata_d = blk_q;
			IDX_GEN_CFG: rdata_d = gen_q;
			default: rdata_d = '0;
		endcase
	end

	// Read data held stable through the acknowledge cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_q <= '0;
		else if (req && !wb_we_i)
			rdata_q <= {16'h0000, rdata_d}; // RULE12
	end

	// Analog control fields straight from the registers
	always_comb
	begin
		charge_pump_o.pd_trans_enable = cp_q[CP_PD_EN_BIT]; // RULE1
		charge_pump_o.fd_enable = cp_q[CP_FD_EN_BIT]; // RULE2
		charge_pump_o.pd_trans_trim = cp_q[CP_PD_TRIM_LSB +: TRIM_W]; // RULE3
		charge_pump_o.fd_trim = cp_q[CP_FD_TRIM_LSB +: TRIM_W]; // RULE3
		serializer_o.clock_power_up = ser_q[SER_CLK_BIT]; // RULE6
		serializer_o.sync_power_up = ser_q[SER_SYNC_BIT]; // RULE7
		serializer_o.data_power_up = {DATA_LANES{ser_q[SER_DATA_BIT]}}; // RULE8
	end

	assign temp_diode_enable_o = temp_en_q[TEMP_EN_BIT]; // RULE4
	assign general_config_o = gen_q;

	// Black pixel mean over 2**black_samples pixels
	black_level_avg #(
		.PIX_W(PIX_W),
		.SAMP_W(BLK_SAMP_W)
	) u_black_avg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.log2_samples_i(blk_q[BLK_SAMP_LSB +: BLK_SAMP_W]), // RULE10
		.black_valid_i(black_valid_i),
		.black_pixel_i(black_pixel_i),
		.mean_o(black_mean),
		.mean_valid_o(mean_valid)
	);

	// Steer pixels to the target black level; no correction before a mean exists
	always_comb
	begin
		corrected = $signed({2'b00, pixel_i}) + $signed({{(PIX_W - BLK_LEVEL_W + 2){1'b0}},
			blk_q[BLK_LEVEL_LSB +: BLK_LEVEL_W]}); // RULE9
		if (mean_valid)
			corrected = corrected - $signed({2'b00, black_mean});
		else
			corrected = $signed({2'b00, pixel_i});
	end

	// Registered pixel output, clamped to the code range
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pixel_q <= '0;
			pixel_valid_q <= 1'b0;
		end
		else
		begin
			pixel_valid_q <= pixel_valid_i;
			if (corrected < 0)
				pixel_q <= '0;
			else if (corrected[PIX_W])
				pixel_q <= '1;
			else
				pixel_q <= corrected[PIX_W-1:0]; // RULE9
		end
	end

	assign pixel_o = pixel_q;
	assign pixel_valid_o = pixel_valid_q;

	// CRC seed follows the select bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			crc_seed_q <= '0;
		else
			crc_seed_q <= {CRC_W{blk_q[CRC_SEED_BIT]}}; // RULE11
	end

	assign crc_seed_o = crc_seed_q;
endmodule : sensor_aux_config_regs

// ---- tb/aux_cfg_properties.sv ----
// Checker for the auxiliary configuration bank, bound to its top.
// Assumes classic Wishbone masters that hold a request until ack.
`timescale 1ns/1ps
module aux_cfg_properties #(
	parameter int CRC_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire aux_cfg_pkg::charge_pump_ctrl_t charge_pump_o,
	input wire logic temp_diode_enable_o,
	input wire logic [aux_cfg_pkg::TEMP_W-1:0] temp_reading_i,
	input wire aux_cfg_pkg::serializer_ctrl_t serializer_o,
	input wire logic [CRC_W-1:0] crc_seed_o
);
	import aux_cfg_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] cp_w;
	logic [5:0] ser_w;
	// Field images of the write data, in carrier order
	assign cp_w = {wb_dat_i[0], wb_dat_i[1], wb_dat_i[10:8], wb_dat_i[14:12]};
	assign ser_w = {wb_dat_i[0], wb_dat_i[1], {4{wb_dat_i[2]}}};
	// Taken only while ack is low, so a held request counts once
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence wr_s(logic [7:0] idx);
		take_s ##0 wb_we_i && wb_sel_i[1:0] == 2'b11 && wb_adr_i[9:2] == idx;
	endsequence
	sequence rd_s(logic [7:0] idx);
		take_s ##0 !wb_we_i && wb_adr_i[9:2] == idx;
	endsequence
	ack_one_a: assert property (take_s |=> wb_ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	reset_vals_a: assert property ($fell(rst_i) |-> charge_pump_o == 8'h11 && serializer_o == 6'h00)
		else $error("bad reset outputs");
	pump_wr_a: assert property (wr_s(8'h48) |=> charge_pump_o == $past(cp_w))
		else $error("pump fields wrong");
	diode_wr_a: assert property (wr_s(8'h60) |=> temp_diode_enable_o == $past(wb_dat_i[0]))
		else $error("diode enable wrong");
	ser_wr_a: assert property (wr_s(8'h70) |=> serializer_o == $past(ser_w))
		else $error("serializer power wrong");
	crc_seed_a: assert property (wr_s(8'h80) |=> ##1 crc_seed_o == {CRC_W{$past(wb_dat_i[15], 2)}})
		else $error("crc seed wrong");
	temp_read_a: assert property (rd_s(8'h61) ##0 $stable(temp_reading_i) |=> wb_dat_o == {24'h000000, $past(temp_reading_i)})
		else $error("temp readout wrong");
	rsvd_read_a: assert property (rd_s(8'h50) or rd_s(8'h51) |=> wb_dat_o == 32'h00000000)
		else $error("reserved word not zero");
endmodule : aux_cfg_properties

bind sensor_aux_config_regs aux_cfg_properties #(.CRC_W(CRC_W)) aux_cfg_properties_inst (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.charge_pump_o, .temp_diode_enable_o, .temp_reading_i, .serializer_o, .crc_seed_o);

// ---- tb/testbench.sv ----
// Self-checking bench for the auxiliary configuration bank.
// Assumes the bound checker and a one-wait-state Wishbone slave.
`timescale 1ns/1ps
module testbench;
	import aux_cfg_pkg::*;
	typedef struct packed {logic [7:0] idx; logic [15:0] rst; logic [15:0] wd; logic [15:0] exp;} row_t;
	logic clk_i = 1'b0;
	logic rst_i, cyc, stb, we, ack, temp_en, bv, pv, pv_o;
	logic [31:0] adr, dat, dat_o;
	logic [3:0] sel;
	logic [15:0] gen, crc, rd;
	logic [7:0] tmp;
	logic [9:0] bp, pix, pix_o;
	charge_pump_ctrl_t cp;
	serializer_ctrl_t ser;
	int num_errors = 0;
	int compares = 0;
	// Index, reset value, write data, readback
	row_t rows [9] = '{
		'{8'h48, 16'h1200, 16'hFFFF, 16'h7703},
		'{8'h50, 16'h0000, 16'hFFFF, 16'h0000},
		'{8'h51, 16'h0000, 16'hFFFF, 16'h0000},
		'{8'h60, 16'h0000, 16'hFFFF, 16'h0001},
		'{8'h61, 16'h005A, 16'hFFFF, 16'h005A},
		'{8'h70, 16'h0000, 16'hFFFF, 16'h0007},
		'{8'h80, 16'h4008, 16'hFFFF, 16'hC7FF},
		'{8'h81, 16'hC001, 16'h1234, 16'h1234},
		'{8'hFF, 16'h0000, 16'hFFFF, 16'h0000}};
	sensor_aux_config_regs sensor_aux_config_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .charge_pump_o(cp), .temp_diode_enable_o(temp_en), .temp_reading_i(tmp),
		.serializer_o(ser), .general_config_o(gen), .black_valid_i(bv), .black_pixel_i(bp),
		.pixel_valid_i(pv), .pixel_i(pix), .pixel_valid_o(pv_o), .pixel_o(pix_o), .crc_seed_o(crc));
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// One classic cycle; a new call leaves an idle cycle first
	task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {22'h000000, idx, 2'b00};
		sel <= s;
		dat <= {16'h0000, d};
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rd = dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rdchk(input string name, input logic [7:0] idx, input logic [15:0] exp);
		wb(1'b0, idx, 16'h0000, 4'hF);
		chk(name, exp, rd);
	endtask : rdchk
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// Watchdog far beyond the 114 cycles needed
	initial
	begin
		#200000;
		num_errors++;
		print_verdict();
	end
	initial
	begin
		{rst_i, cyc, stb, we, bv, pv} = 6'h20;
		tmp = 8'h5A;
		{adr, dat, sel, bp, pix} = '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			rdchk("reset value", rows[i].idx, rows[i].rst);
			wb(1'b1, rows[i].idx, rows[i].wd, 4'hF);
			rdchk("readback", rows[i].idx, rows[i].exp);
		end
		chk("pump", 16'h00FF, {8'h00, cp});
		chk("serializer", 16'h003F, {10'h000, ser});
		chk("crc seed", 16'hFFFF, crc);
		chk("general config", 16'h1234, gen);
		chk("diode on", 16'h0001, {15'h0000, temp_en});
		wb(1'b1, 8'h70, 16'h0002, 4'hF);
		chk("sync only", 16'h0010, {10'h000, ser});
		// Low lane only: trims must survive
		wb(1'b1, 8'h48, 16'h0000, 4'h1);
		rdchk("low lane", 8'h48, 16'h7700);
		// Second reset in mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("pump reset", 8'h48, 16'h1200);
		rdchk("blackcal reset", 8'h80, 16'h4008);
		chk("diode", 16'h0000, {15'h0000, temp_en});
		chk("general reset", 16'hC001, gen);
		chk("crc reset", 16'h0000, crc);
		chk("serializer reset", 16'h0000, {10'h000, ser});
		// A fresh reading must reach the readout word
		tmp <= 8'hC3;
		rdchk("temp change", 8'h61, 16'h00C3);
		// Level 0x10, four black pixels 10..40, mean 25
		wb(1'b1, 8'h80, 16'h0210, 4'hF);
		for (int i = 1; i < 5; i++)
		begin
			@(posedge clk_i);
			bv <= 1'b1;
			bp <= 10'(10 * i);
		end
		@(posedge clk_i);
		bv <= 1'b0;
		pv <= 1'b1;
		pix <= 10'h064;
		@(posedge clk_i);
		pv <= 1'b0;
		#1;
		chk("pixel", 16'h005B, {6'h00, pix_o});
		chk("pixel valid", 16'h0001, {15'h0000, pv_o});
		print_verdict();
	end
endmodule : testbench
